// file: inc/twfce_pkg.sv
// Package: register map, command fields, bus timing and carrier types
package twfce_pkg;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] TXDAT_OFS    = 8'h10;
  localparam logic [7:0] RXDAT_OFS    = 8'h14;
  localparam logic [7:0] CMD_OFS      = 8'h18;
  localparam logic [7:0] FIFOCTL_OFS  = 8'h1c;
  localparam logic [7:0] FIFOSTAT_OFS = 8'h20;
  localparam logic [7:0] DATCNT_OFS   = 8'h24;
  localparam logic [7:0] RCNT_OFS     = 8'h28;

  // ****************************************************
  // Command word fields
  // ****************************************************
  localparam int CMD_START_BIT   = 0;
  localparam int CMD_AS_LSB      = 1;
  localparam int CMD_RESTART_BIT = 4;
  localparam int CMD_SAS_LSB     = 5;
  localparam int CMD_DATA_BIT    = 8;
  localparam int CMD_NACK_BIT    = 9;
  localparam int CMD_STOP_BIT    = 10;
  localparam int CMD_ROLE_BIT    = 11;
  localparam int CMD_DIR_BIT     = 12;
  localparam int CMD_EXEC_BIT    = 15;
  localparam int CMD_WIDTH       = 16;
  localparam int LEN_WIDTH       = 3;

  localparam int FCTL_NIB_BIT = 0;
  localparam int FCTL_RFR_BIT = 1;
  localparam int FCTL_TFR_BIT = 2;

  localparam int STAT_COMMAND_COMPLETE_BIT = 0;
  localparam int STAT_RNB_BIT  = 1;
  localparam int STAT_RFE_BIT  = 2;
  localparam int STAT_RFF_BIT  = 3;
  localparam int STAT_TFE_BIT  = 4;
  localparam int STAT_TFF_BIT  = 5;
  localparam int STAT_WRS_BIT  = 6;
  localparam int STAT_RFD_LSB  = 8;
  localparam int STAT_TFD_LSB  = 16;

  localparam int CNT_WIDTH  = 10;
  localparam int FIFO_DEPTH = 128;
  localparam int LVL_WIDTH  = 8;

  // ****************************************************
  // Bus timing: one quarter of the bit period in sys clocks
  // ****************************************************
  localparam int SYS_CLK_HZ  = 20_000_000;
  localparam int BUS_RATE_HZ = 100_000;
  localparam int QTR_CYCLES  = SYS_CLK_HZ / (BUS_RATE_HZ * 4);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);

  // ****************************************************
  // Carrier types
  // ****************************************************
  typedef struct packed {
    logic                 exec;
    logic                 dir;
    logic                 role;
    logic                 stop_en;
    logic                 nack_sel;
    logic                 data_en;
    logic [LEN_WIDTH-1:0] second_len;
    logic                 restart_en;
    logic [LEN_WIDTH-1:0] first_len;
    logic                 start_en;
  } twfce_cmd_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } twfce_bus_type;

endpackage : twfce_pkg

// file: rtl/twfce_fifo.sv
// Byte FIFO with registered read data and occupancy count
module twfce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int LW    = 8
) (
  input  wire logic             sys_clk_in,  // System clock
  input  wire logic             srst_in,     // Sync reset / flush
  input  wire logic             push_in,     // Write strobe
  input  wire logic [WIDTH-1:0] wdata_in,    // Write data
  input  wire logic             pop_in,      // Read strobe
  output logic      [WIDTH-1:0] rdata_out,   // Oldest entry, registered
  output logic      [LW-1:0]    level_out    // Occupancy
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic             do_push;
  logic             do_pop;

  assign do_push = push_in && (level_out != LW'(DEPTH));
  assign do_pop  = pop_in && (level_out != '0);

  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem_reg[wptr_reg] <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      level_out <= '0;
      rdata_out <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + AW'(1);
      end
      if (do_pop) begin
        rptr_reg  <= rptr_reg + AW'(1);
      end
      // Show-ahead: the head stands before it is popped, so a reader
      // takes it in the pop cycle; a push lands two edges later
      rdata_out <= mem_reg[rptr_reg + AW'(do_pop)];
      level_out <= level_out + LW'(do_push) - LW'(do_pop);
    end
  end
endmodule : twfce_fifo

// file: rtl/twfce_engine.sv
// Two-wire command-list engine with transmit and receive FIFOs
module twfce_engine (
  input  wire logic        sys_clk_in,   // 20 MHz clock
  input  wire logic        srst_in,      // Sync reset, high
  input  wire logic [7:0]  addr_in,      // Register byte address
  input  wire logic [31:0] wdata_in,     // Write data
  input  wire logic        wr_in,        // Write strobe
  input  wire logic        rd_in,        // Read strobe
  output logic      [31:0] rdata_out,    // Read data, next cycle
  input  wire logic        scl_in,       // Bus clock pin level
  output logic             scl_out,      // Bus clock drive value
  output logic             scl_oe_out,   // Pull bus clock low
  input  wire logic        sda_in,       // Bus data pin level
  output logic             sda_out,      // Bus data drive value
  output logic             sda_oe_out,   // Pull bus data low
  output logic             irq_out       // Error / FIFO condition
);
  // ****************************************************
  // Registers and FIFOs
  // ****************************************************
  twfce_pkg::twfce_cmd_type cmd_reg;
  logic [twfce_pkg::CNT_WIDTH-1:0] cnt_reg, remain_reg;
  logic nib_reg, tfr_reg, rfr_reg, done_reg, nerr_reg;
  logic [7:0] txq_data, rxq_data;
  logic [twfce_pkg::LVL_WIDTH-1:0] txq_lvl, rxq_lvl;
  logic txq_pop, rxq_push;
  logic [7:0] rx_byte_reg;
  logic [2:0] sda_sy_reg, scl_sy_reg;
  logic sda_s, scl_s, ack_bit_reg;

  localparam logic [twfce_pkg::LVL_WIDTH-1:0] LVL_FULL =
    twfce_pkg::LVL_WIDTH'(twfce_pkg::FIFO_DEPTH);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  twfce_fifo #(.WIDTH(8), .DEPTH(twfce_pkg::FIFO_DEPTH),
               .LW(twfce_pkg::LVL_WIDTH)) u_txq (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in || tfr_reg),
    .push_in    (wr_in && hit(addr_in, twfce_pkg::TXDAT_OFS)),
    .wdata_in   (wdata_in[7:0]),
    .pop_in     (txq_pop),
    .rdata_out  (txq_data),
    .level_out  (txq_lvl)
  );

  twfce_fifo #(.WIDTH(8), .DEPTH(twfce_pkg::FIFO_DEPTH),
               .LW(twfce_pkg::LVL_WIDTH)) u_rxq (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in || rfr_reg),
    .push_in    (rxq_push),
    .wdata_in   (rx_byte_reg),
    .pop_in     (rd_in && hit(addr_in, twfce_pkg::RXDAT_OFS)),
    .rdata_out  (rxq_data),
    .level_out  (rxq_lvl)
  );

  // ****************************************************
  // Pin synchronisers: 2nd and 3rd stage must agree
  // ****************************************************
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sda_sy_reg <= 3'h7;
      scl_sy_reg <= 3'h7;
      sda_s      <= 1'b1;
      scl_s      <= 1'b1;
    end else begin
      sda_sy_reg <= {sda_sy_reg[1:0], sda_in};
      scl_sy_reg <= {scl_sy_reg[1:0], scl_in};
      if (sda_sy_reg[1] == sda_sy_reg[2]) sda_s <= sda_sy_reg[2];
      if (scl_sy_reg[1] == scl_sy_reg[2]) scl_s <= scl_sy_reg[2];
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_START, S_ADDR1, S_RESTART, S_ADDR2, S_DATA, S_STOP, S_DONE
  } twfce_phase_type;
  twfce_phase_type phase_reg;
  logic [2:0] bytes_left_reg;
  logic [3:0] bit_reg;
  logic [1:0] qtr_reg;
  logic [7:0] tick_reg;
  logic [7:0] sh_reg;
  logic       reading_reg, first_reg, tick, last_qtr, byte_end;
  logic       is_read, nack_seen, step;

  assign tick     = tick_reg == twfce_pkg::QTR_LAST;
  assign last_qtr = tick && qtr_reg == 2'h3;
  assign byte_end = last_qtr && bit_reg == 4'h8;
  // Slave: bit 12 picks direction; master: first address LSB
  assign is_read  = cmd_reg.role ? reading_reg : cmd_reg.dir;
  // Acknowledge is held from mid-bit, since the far side lets go at the fall
  assign nack_seen = byte_end && !is_read && ack_bit_reg;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || phase_reg == S_IDLE || tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  // Advance to the next enabled phase in fixed order
  function automatic twfce_phase_type next_phase(
      input twfce_phase_type p, input twfce_pkg::twfce_cmd_type c);
    twfce_phase_type n;
    n = S_DONE;
    unique case (p)
      S_IDLE:    n = c.start_en ? S_START : next_phase1(S_START, c);
      default:   n = next_phase1(p, c);
    endcase
    return n;
  endfunction : next_phase

  function automatic twfce_phase_type next_phase1(
      input twfce_phase_type p, input twfce_pkg::twfce_cmd_type c);
    twfce_phase_type n;
    n = S_DONE;
    if (p == S_START && c.first_len != '0) n = S_ADDR1;
    else if (p <= S_ADDR1 && c.restart_en) n = S_RESTART;
    else if (p <= S_RESTART && c.second_len != '0) n = S_ADDR2;
    else if (p <= S_ADDR2 && c.data_en) n = S_DATA;
    else if (p <= S_DATA && c.stop_en) n = S_STOP;
    return n;
  endfunction : next_phase1

  assign step = (phase_reg == S_START || phase_reg == S_RESTART ||
                 phase_reg == S_STOP) ? last_qtr : byte_end;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      phase_reg      <= S_IDLE;
      bytes_left_reg <= '0;
      remain_reg     <= '0;
      qtr_reg        <= '0;
      bit_reg        <= '0;
      reading_reg    <= 1'b0;
      first_reg      <= 1'b0;
    end else if (phase_reg == S_IDLE) begin
      qtr_reg <= '0;
      bit_reg <= '0;
      if (cmd_reg.exec && !done_reg) begin
        phase_reg  <= next_phase(S_IDLE, cmd_reg);
        remain_reg <= cmd_reg.data_en ? cnt_reg : '0;
        first_reg  <= 1'b1;
        reading_reg <= 1'b0;
        bytes_left_reg <= cmd_reg.first_len;
      end
    end else if (phase_reg == S_DONE) begin
      phase_reg <= S_IDLE;
    end else if (nack_seen && !nib_reg &&
                 !(phase_reg == S_DATA && remain_reg == 1)) begin
      phase_reg <= S_DONE;
    end else if (tick) begin
      qtr_reg <= qtr_reg + 2'h1;
      if (last_qtr && phase_reg != S_START &&
          phase_reg != S_RESTART && phase_reg != S_STOP) begin
        bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
        if (bit_reg == 4'h8 && first_reg) begin
          reading_reg <= rx_byte_reg[0];
          first_reg   <= 1'b0;
        end
      end
      if (step) begin
        if (phase_reg == S_DATA) remain_reg <= remain_reg - 10'h1;
        if ((phase_reg == S_ADDR1 || phase_reg == S_ADDR2) &&
            bytes_left_reg > 3'h1) begin
          bytes_left_reg <= bytes_left_reg - 3'h1;
        end else if (phase_reg == S_DATA && remain_reg > 10'h1) begin
          phase_reg <= S_DATA;
        end else begin
          phase_reg <= next_phase(phase_reg, cmd_reg);
          bytes_left_reg <=
            (next_phase(phase_reg, cmd_reg) == S_ADDR1) ?
            cmd_reg.first_len : cmd_reg.second_len;
          if (phase_reg == S_RESTART) first_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************************
  // Byte shifter and pin drive
  // ****************************************************
  logic shifting;
  assign shifting = phase_reg == S_ADDR1 || phase_reg == S_ADDR2 ||
                    phase_reg == S_DATA;
  assign txq_pop  = shifting && !(phase_reg == S_DATA && is_read) &&
                    tick_reg == '0 && qtr_reg == 2'h0 && bit_reg == 4'h0;
  assign rxq_push = phase_reg == S_DATA && is_read && byte_end &&
                    rxq_lvl != LVL_FULL;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sh_reg      <= '0;
      rx_byte_reg <= '0;
      ack_bit_reg <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe_out  <= 1'b0;
      scl_out     <= 1'b0;
      scl_oe_out  <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      // Load while the clock is low so the first bit settles early
      if (txq_pop) begin
        sh_reg <= txq_data;
      end
      if (shifting && tick && qtr_reg == 2'h2 && bit_reg == 4'h8) begin
        ack_bit_reg <= sda_s;
      end
      if (shifting && tick && qtr_reg == 2'h2 && bit_reg < 4'h8) begin
        rx_byte_reg <= {rx_byte_reg[6:0], sda_s};
      end
      if (shifting && last_qtr && bit_reg < 4'h8) begin
        sh_reg <= {sh_reg[6:0], 1'b0};
      end
      // Clock low in quarters 0 and 3 while master runs the list, but only in quarter 0 of the stop
      scl_oe_out <= cmd_reg.role && phase_reg != S_IDLE &&
                    phase_reg != S_DONE &&
                    (qtr_reg == 2'h0 || qtr_reg == 2'h3) &&
                    !(phase_reg == S_STOP && qtr_reg == 2'h3);
      unique case (phase_reg)
        S_START, S_RESTART: sda_oe_out <= qtr_reg >= 2'h2;
        S_STOP:             sda_oe_out <= qtr_reg < 2'h2;
        S_ADDR1, S_ADDR2, S_DATA: begin
          if (bit_reg == 4'h8) begin
            // Ack own reads; NACK the last one if selected
            sda_oe_out <= phase_reg == S_DATA && is_read &&
                          !(cmd_reg.nack_sel && remain_reg == 1);
          end else if (phase_reg == S_DATA && is_read) begin
            sda_oe_out <= 1'b0;
          end else begin
            sda_oe_out <= !sh_reg[7];
          end
        end
        default:            sda_oe_out <= 1'b0;
      endcase
    end
  end

  // ****************************************************
  // Register file
  // ****************************************************
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cmd_reg <= '0;
      cnt_reg <= '0;
      nib_reg <= 1'b0;
      tfr_reg <= 1'b0;
      rfr_reg <= 1'b0;
    end else begin
      tfr_reg <= 1'b0;
      rfr_reg <= 1'b0;
      if (phase_reg == S_DONE) cmd_reg.exec <= 1'b0;
      if (wr_in && hit(addr_in, twfce_pkg::CMD_OFS)) begin
        cmd_reg <= {wdata_in[twfce_pkg::CMD_EXEC_BIT],
                    wdata_in[twfce_pkg::CMD_DIR_BIT:0]};
      end
      if (wr_in && hit(addr_in, twfce_pkg::DATCNT_OFS)) begin
        cnt_reg <= wdata_in[twfce_pkg::CNT_WIDTH-1:0];
      end
      if (wr_in && hit(addr_in, twfce_pkg::FIFOCTL_OFS)) begin
        nib_reg <= wdata_in[twfce_pkg::FCTL_NIB_BIT];
        tfr_reg <= wdata_in[twfce_pkg::FCTL_TFR_BIT];
        rfr_reg <= wdata_in[twfce_pkg::FCTL_RFR_BIT];
      end
    end
  end

  // Status: set wins over a same-cycle clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      done_reg <= 1'b1;
      nerr_reg <= 1'b0;
    end else begin
      if (phase_reg == S_DONE) done_reg <= 1'b1;
      else if (phase_reg == S_IDLE && cmd_reg.exec) done_reg <= 1'b0;
      if (nack_seen && !nib_reg &&
          !(phase_reg == S_DATA && remain_reg == 1)) begin
        nerr_reg <= 1'b1;
      end else if (wr_in && hit(addr_in, twfce_pkg::FIFOSTAT_OFS) &&
                   wdata_in[twfce_pkg::STAT_RNB_BIT]) begin
        nerr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq_out     <= 1'b0;
      rdata_out   <= '0;
    end else begin
      irq_out <= nerr_reg ||
                 (cmd_reg.exec && (txq_lvl == '0 ||
                                   rxq_lvl == LVL_FULL));
      rdata_out <= '0;
      if (rd_in) begin
        unique case (addr_in)
          twfce_pkg::RXDAT_OFS:   rdata_out <= 32'(rxq_data);
          twfce_pkg::CMD_OFS:     rdata_out <= {16'h0, cmd_reg.exec, 2'h0,
                                                13'(cmd_reg)};
          twfce_pkg::FIFOCTL_OFS: rdata_out <= {29'h0, tfr_reg, rfr_reg,
                                                nib_reg};
          twfce_pkg::FIFOSTAT_OFS: rdata_out <= {8'h0, txq_lvl, rxq_lvl,
            1'b0, cmd_reg.dir, txq_lvl == LVL_FULL, txq_lvl != '0,
            rxq_lvl == LVL_FULL, rxq_lvl != '0, nerr_reg, done_reg};
          twfce_pkg::DATCNT_OFS:  rdata_out <= 32'(cnt_reg);
          twfce_pkg::RCNT_OFS:    rdata_out <= 32'(remain_reg);
          default:                rdata_out <= '0;
        endcase
      end
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_done_clears: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    phase_reg == S_DONE |=> done_reg && !cmd_reg.exec)
    else $error("complete bit not set after list end");
  a_nack_halts: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    nack_seen && !nib_reg && phase_reg != S_DATA |=> phase_reg == S_DONE)
    else $error("unignored nack did not halt");
  a_nib_keeps: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    nack_seen && nib_reg && !nerr_reg |=> !nerr_reg)
    else $error("ignored nack raised error");
  a_tfr_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    tfr_reg |=> txq_lvl == '0 && !tfr_reg)
    else $error("tx reset incomplete");
  a_rfr_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    rfr_reg |=> rxq_lvl == '0 && !rfr_reg)
    else $error("rx reset incomplete");
  a_idle_no_exec: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !cmd_reg.exec && phase_reg == S_IDLE |=> phase_reg == S_IDLE)
    else $error("list ran without execute");
  a_rx_full_irq: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    cmd_reg.exec && rxq_lvl == LVL_FULL |=> irq_out)
    else $error("full rx without irq");
  a_err_irq: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    nerr_reg |=> irq_out)
    else $error("error without irq");
  c_run: cover property (@(posedge sys_clk_in) phase_reg == S_DATA);
  c_nack: cover property (@(posedge sys_clk_in) nack_seen);
  c_stop: cover property (@(posedge sys_clk_in) phase_reg == S_STOP);
endmodule : twfce_engine

// file: dv/twfce_slave_model.sv
// Two-wire bus slave model: records, acknowledges and serves bytes
module twfce_slave_model (
  input  wire logic scl_in,     // Bus clock line
  input  wire logic sda_in,     // Bus data line
  input  wire logic nack_in,    // Refuse second byte of a frame
  output logic      sda_oe_out  // Pull data line low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic [7:0] rd_byte = 8'ha5;
  logic       rdm     = 1'b0;
  logic       first   = 1'b1;
  logic       mnack   = 1'b0;
  int         bits    = 0;
  int         nbyte   = 0;
  logic [7:0] got_q[$];
  logic       ack_q[$];
  initial sda_oe_out = 1'b0;
  // Start or restart opens a frame whose first byte sets direction
  always @(negedge sda_in) if (scl_in) begin
    bits = 0;
    nbyte = 0;
    first = 1'b1;
    rdm = 1'b0;
    mnack = 1'b0;
  end
  always @(posedge sda_in) if (scl_in) begin
    rdm = 1'b0;
    sda_oe_out = 1'b0;
  end
  always @(posedge scl_in) begin
    if (bits < 8) sh = {sh[6:0], sda_in};
    else if (rdm && bits == 8) begin
      ack_q.push_back(sda_in);
      mnack = sda_in;
      rd_byte = rd_byte + 8'h01;
    end
    bits++;
  end
  // Data only moves while the clock is low
  always @(negedge scl_in) begin
    if (bits == 8 && !rdm) begin
      got_q.push_back(sh);
      sda_oe_out = !(nack_in && nbyte == 1);
    end else if (bits == 9) begin
      bits = 0;
      nbyte++;
      if (first) rdm = sh[0];
      first = 1'b0;
      // Released after a master NACK so the stop can be seen
      sda_oe_out = rdm && !mnack && !rd_byte[7];
    end else if (rdm) begin
      sda_oe_out = bits < 8 && !rd_byte[7-bits];
    end
  end
endmodule : twfce_slave_model

// file: dv/tb_two_wire_fifo_command_engine.sv
// Testbench for the command-list engine against a slave model
module tb_two_wire_fifo_command_engine;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wdata_in   = 32'h0;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        nack_mode  = 1'b0;
  logic [31:0] rdata_out, rv;
  logic        scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, slv_oe;
  logic [7:0]  exp_q[$];
  int          failures     = 0;
  int          total_checks = 0;
  int          seed         = 32'h23b82376;
  // Both lines have pull-ups
  wire scl_line = !scl_oe_out;
  wire sda_line = !(sda_oe_out || slv_oe);
  always #25 sys_clk_in = !sys_clk_in;
  twfce_engine DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .irq_out(irq_out));
  twfce_slave_model u_slave (.scl_in(scl_line), .sda_in(sda_line),
    .nack_in(nack_mode), .sda_oe_out(slv_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd
  // Load bytes and command (count is written beforehand), then poll status under a bound
  task automatic run(input logic [31:0] cmd, input logic [31:0] mask);
    int i;
    foreach (exp_q[i]) wr(8'h10, {24'h0, exp_q[i]});
    wr(8'h18, cmd);
    repeat (40) @(posedge sys_clk_in);
    for (i = 0; i < 20000; i++) begin
      rd(8'h20);
      if ((rv & mask) != 0) break;
    end
    chk(i < 20000, 1);
  endtask : run
  task automatic bytes_chk();
    chk(u_slave.got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(u_slave.got_q[i], exp_q[i]);
    u_slave.got_q.delete();
  endtask : bytes_chk
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #4_000_000;
    failures++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rd(8'h18); chk(rv, 0);
    rd(8'h20); chk(rv, 32'h1);
    rd(8'h3c); chk(rv, 0);
    wr(8'h24, 32'hffffffff);
    rd(8'h24); chk(rv, 32'h3ff);
    for (int i = 0; i < 3; i++) wr(8'h10, $random(seed) & 32'hff);
    rd(8'h20); chk(rv[23:16], 3);
    wr(8'h1c, 32'h4);
    rd(8'h1c); chk(rv, 0);
    rd(8'h20); chk(rv[23:16], 0);
    $display("register test done");
    // Everything is loaded before the execute bit is set
    exp_q = {8'ha0};
    for (int i = 0; i < 5; i++) exp_q.push_back(8'($random(seed)));
    wr(8'h24, 32'h4);
    run(32'h8d05, 32'h1);
    bytes_chk();
    rd(8'h20); chk(rv[1], 0);
    $display("write test done");
    exp_q = {8'ha0, 8'($random(seed)), 8'ha1};
    wr(8'h24, 32'h3);
    run(32'h8f35, 32'h1);
    bytes_chk();
    chk({u_slave.ack_q[0], u_slave.ack_q[1], u_slave.ack_q[2]}, 3'b001);
    rd(8'h14); chk(rv, 32'ha5);
    rd(8'h14); chk(rv, 32'ha6);
    rd(8'h20); chk(rv[15:8], 1);
    wr(8'h1c, 32'h2);
    rd(8'h1c); chk(rv, 0);
    rd(8'h20); chk(rv[15:8], 0);
    $display("read test done");
    nack_mode = 1'b1;
    wr(8'h1c, 32'h1);
    exp_q = {8'ha0};
    for (int i = 0; i < 3; i++) exp_q.push_back(8'($random(seed)));
    wr(8'h24, 32'h2);
    run(32'h8d05, 32'h1);
    bytes_chk();
    rd(8'h20); chk(rv[1], 0);
    $display("ignore test done");
    wr(8'h1c, 32'h0);
    run(32'h8d05, 32'h2);
    chk(rv[1], 1);
    chk(irq_out, 1);
    wr(8'h20, 32'h2);
    rd(8'h20); chk(rv[1], 0);
    $display("error test done");
    summarize();
  end
endmodule : tb_two_wire_fifo_command_engine
